// [hsc_pkg.sv]
// Purpose: shared constants for the host control/status register front end
// Assumes: 20 MHz ref_clk_i, byte offsets on a 5-bit register port
// Notes:   event bits are sticky, cleared by writing ones
package hsc_pkg;
    // register byte offsets
    localparam logic [4:0]  OFS_STAT_CMD = 5'h00;
    localparam logic [4:0]  OFS_GEN_PTR  = 5'h04;
    localparam logic [4:0]  OFS_PORT     = 5'h08;
    localparam logic [4:0]  OFS_NVM      = 5'h0C;
    localparam logic [4:0]  OFS_MGMT     = 5'h10;
    // event vector holds status bits 15:8, index = bit - 8
    localparam int          EV_CX        = 7;
    localparam int          EV_FR        = 6;
    localparam int          EV_CNA       = 5;
    localparam int          EV_RNR       = 4;
    localparam int          EV_MDI       = 3;
    localparam int          EV_SWI       = 2;
    localparam int          EV_RSVD      = 1;
    localparam int          EV_FCP       = 0;
    localparam logic [7:0]  EV_RESET     = 8'h00;
    // command word positions
    localparam int          CM_SWI       = 25;
    localparam int          CM_GMASK     = 24;
    localparam int          CM_CUC_LO    = 20;
    localparam int          CM_RUC_LO    = 16;
    localparam logic [5:0]  CM_MASK_RST  = 6'h00;
    // management control positions
    localparam int          MG_IE        = 29;
    localparam int          MG_RDY       = 28;
    localparam int          MG_OP_LO     = 26;
    localparam int          MG_PHY_LO    = 21;
    localparam int          MG_REG_LO    = 16;
    localparam logic [1:0]  OP_WRITE     = 2'h1;
    localparam logic [1:0]  OP_READ      = 2'h2;
    // unit state codes
    localparam logic [1:0]  CU_IDLE      = 2'h0;
    localparam logic [1:0]  CU_SUSP      = 2'h1;
    localparam logic [1:0]  CU_ACTIVE    = 2'h2;
    localparam logic [3:0]  RU_READY     = 4'h4;
    // nonvolatile control bits
    localparam int          FL_WE        = 0;
    localparam int          EE_SK        = 16;
    localparam int          EE_CS        = 17;
    localparam int          EE_DI        = 18;
    localparam int          EE_DO        = 19;
    // management clock timing: least half period 200 ns
    localparam int          CLK_NS       = 50;
    localparam int          MDC_HALF_NS  = 200;
    localparam int          MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0]  DIV_LAST     = 3'(MDC_HALF_CYC - 1);
    // serial frame layout
    localparam logic [31:0] PREAMBLE     = 32'hFFFF_FFFF;
    localparam logic [1:0]  FR_START     = 2'h1;
    localparam logic [1:0]  TA_WRITE     = 2'h2;
    localparam logic [1:0]  TA_READ      = 2'h3;
    localparam logic [5:0]  BIT_TA       = 6'h2E;
    localparam logic [5:0]  BIT_DATA     = 6'h30;
    localparam logic [5:0]  BIT_LAST     = 6'h3F;
    typedef enum logic [1:0] {
        MS_IDLE  = 2'b01,
        MS_SHIFT = 2'b10
    } hsc_mstate_t;
endpackage

// [hsc_mdio_shifter.sv]
// Purpose: serial management frame engine toward the PHY
// Assumes: start_i only while busy_o is low
// Notes:   one frame is 64 bits, 8 clocks per bit
module hsc_mdio_shifter
(
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        start_i,
    input  wire logic [1:0]  op_i,
    input  wire logic [4:0]  phy_addr_i,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic [15:0] wdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [15:0]      rdata_o,
    output logic             mdc_o,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_o
);
    import hsc_pkg::*;

    hsc_mstate_t st_q, st_d;
    logic [63:0] frm_q, frm_d;
    logic [5:0]  cnt_q, cnt_d;
    logic [2:0]  div_q, div_d;
    logic [15:0] rdat_q, rdat_d;
    logic        mdc_q, mdc_d;
    logic        rd_q, rd_d;
    logic        done_q, done_d;
    logic [1:0]  sync_q;
    logic        tick;

    assign tick = (div_q == DIV_LAST);

    always_comb
    begin
        st_d   = st_q;
        frm_d  = frm_q;
        cnt_d  = cnt_q;
        div_d  = div_q;
        rdat_d = rdat_q;
        mdc_d  = mdc_q;
        rd_d   = rd_q;
        done_d = 1'b0;
        case (st_q)
            MS_IDLE:
            begin
                if (start_i)
                begin
                    rd_d  = (op_i == OP_READ);
                    // read frames leave the bus released from the turnaround on
                    frm_d = {PREAMBLE, FR_START, op_i, phy_addr_i, reg_addr_i,
                             rd_d ? TA_READ : TA_WRITE,
                             rd_d ? 16'hFFFF : wdata_i};
                    cnt_d = 6'h00;
                    div_d = 3'h0;
                    mdc_d = 1'b0;
                    st_d  = MS_SHIFT;
                end
            end
            MS_SHIFT:
            begin
                div_d = tick ? 3'h0 : div_q + 3'h1;
                if (tick)
                begin
                    mdc_d = ~mdc_q;
                    if (mdc_q)
                    begin
                        // sample before the falling edge: the PHY drove
                        // this bit after the previous falling edge
                        if (rd_q && cnt_q >= BIT_DATA)
                            rdat_d = {rdat_q[14:0], sync_q[1]};
                        frm_d = {frm_q[62:0], 1'b0};
                        cnt_d = cnt_q + 6'h01;
                        if (cnt_q == BIT_LAST)
                        begin
                            st_d   = MS_IDLE;
                            done_d = 1'b1;
                        end
                    end
                end
            end
            default:
                st_d = MS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            st_q   <= MS_IDLE;
            frm_q  <= 64'h0;
            cnt_q  <= 6'h00;
            div_q  <= 3'h0;
            rdat_q <= 16'h0000;
            mdc_q  <= 1'b0;
            rd_q   <= 1'b0;
            done_q <= 1'b0;
            sync_q <= 2'h0;
        end
        else
        begin
            st_q   <= st_d;
            frm_q  <= frm_d;
            cnt_q  <= cnt_d;
            div_q  <= div_d;
            rdat_q <= rdat_d;
            mdc_q  <= mdc_d;
            rd_q   <= rd_d;
            done_q <= done_d;
            sync_q <= {sync_q[0], mdio_i};
        end
    end

    assign busy_o    = (st_q != MS_IDLE);
    assign done_o    = done_q;
    assign rdata_o   = rdat_q;
    assign mdc_o     = mdc_q;
    assign mdio_o    = frm_q[63];
    assign mdio_oe_o = (st_q == MS_SHIFT) && !(rd_q && cnt_q >= BIT_TA);

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_frame_length: assert property (
        (st_q == MS_IDLE && start_i) |-> ##[510:514] done_q)
        else $error("management frame did not end in 64 bit times");
    a_read_release: assert property (
        (rd_q && st_q == MS_SHIFT && cnt_q >= BIT_TA) |-> !mdio_oe_o)
        else $error("bus driven during read turnaround or data");
    cover property (done_q && rd_q);
endmodule

// [hsc_csr.sv]
// Purpose: host control/status registers, interrupt line, PHY management
// Assumes: unit inputs share ref_clk_i; eep_do_i and mdio_i are pins
// Notes:   reads answer one cycle after csr_rd_i
module hsc_csr
(
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [4:0]  csr_addr_i,
    input  wire logic        csr_wr_i,
    input  wire logic        csr_rd_i,
    input  wire logic [3:0]  csr_be_i,
    input  wire logic [31:0] csr_wdata_i,
    output logic [31:0]      csr_rdata_o,
    input  wire logic        cu_cmd_done_i,
    input  wire logic        rx_frame_done_i,
    input  wire logic        flow_pause_i,
    input  wire logic [1:0]  cu_state_i,
    input  wire logic [3:0]  ru_state_i,
    output logic [3:0]       cu_cmd_o,
    output logic             cu_cmd_stb_o,
    output logic [3:0]       ru_cmd_o,
    output logic             ru_cmd_stb_o,
    output logic [31:0]      gen_ptr_o,
    output logic [3:0]       port_func_o,
    output logic [27:0]      port_arg_o,
    output logic             port_stb_o,
    output logic             flash_wr_en_o,
    output logic             eep_sk_o,
    output logic             eep_cs_o,
    output logic             eep_di_o,
    input  wire logic        eep_do_i,
    output logic             mdc_o,
    input  wire logic        mdio_i,
    output logic             mdio_o,
    output logic             mdio_oe_o,
    output logic             inta_n_o
);
    import hsc_pkg::*;

    logic [7:0]  ev_q, ev_d, ev_set, ev_clr;
    logic [5:0]  mask_q, mask_d;
    logic        gmask_q, gmask_d;
    logic [3:0]  cuc_q, cuc_d, ruc_q, ruc_d;
    logic        cstb_q, cstb_d, rstb_q, rstb_d;
    logic [31:0] gptr_q, gptr_d, port_q, port_d;
    logic        pstb_q, pstb_d;
    logic        fl_we_q, fl_we_d;
    logic [2:0]  ee_q, ee_d;
    logic        mg_ie_q, mg_ie_d, mg_rdy_q, mg_rdy_d;
    logic [1:0]  mg_op_q, mg_op_d;
    logic [4:0]  mg_phy_q, mg_phy_d, mg_reg_q, mg_reg_d;
    logic [15:0] mg_dat_q, mg_dat_d;
    logic        mg_go_q, mg_go_d;
    logic [1:0]  cu_prev_q;
    logic [3:0]  ru_prev_q;
    logic [31:0] rdata_q, rdata_d;
    logic        inta_n_q, inta_n_d;
    logic [1:0]  eep_sync_q;
    logic [15:0] status_w;
    logic        wr_sc, wr_gp, wr_pt, wr_nv, wr_mg;
    logic        mg_busy, mg_done;
    logic [15:0] mg_rdata;
    logic        pend;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    assign wr_sc = csr_wr_i && (csr_addr_i == OFS_STAT_CMD);
    assign wr_gp = csr_wr_i && (csr_addr_i == OFS_GEN_PTR);
    assign wr_pt = csr_wr_i && (csr_addr_i == OFS_PORT);
    assign wr_nv = csr_wr_i && (csr_addr_i == OFS_NVM);
    assign wr_mg = csr_wr_i && (csr_addr_i == OFS_MGMT);

    // reserved status positions are forced to zero here, so a stray
    // write of ones there cannot make them read back set
    assign status_w = {ev_q[7:2], 1'b0, ev_q[EV_FCP],
                       cu_state_i, ru_state_i, 2'b00};

    always_comb
    begin
        ev_set          = 8'h00;
        ev_set[EV_CX]   = cu_cmd_done_i;
        ev_set[EV_FR]   = rx_frame_done_i;
        ev_set[EV_CNA]  = (cu_prev_q == CU_ACTIVE) &&
                          (cu_state_i == CU_IDLE ||
                           cu_state_i == CU_SUSP);
        ev_set[EV_RNR]  = (ru_prev_q == RU_READY) &&
                          (ru_state_i != RU_READY);
        ev_set[EV_MDI]  = mg_done;
        ev_set[EV_SWI]  = wr_sc && csr_be_i[3] &&
                          csr_wdata_i[CM_SWI];
        ev_set[EV_FCP]  = flow_pause_i;
        ev_clr          = (wr_sc && csr_be_i[1]) ? csr_wdata_i[15:8] : 8'h00;
        // a new event beats an acknowledge landing in the same cycle
        ev_d            = (ev_q & ~ev_clr) | ev_set;
        ev_d[EV_RSVD]   = 1'b0;

        mask_d  = mask_q;
        gmask_d = gmask_q;
        cuc_d   = cuc_q;
        ruc_d   = ruc_q;
        cstb_d  = 1'b0;
        rstb_d  = 1'b0;
        if (wr_sc && csr_be_i[3])
        begin
            mask_d  = csr_wdata_i[31:26];
            gmask_d = csr_wdata_i[CM_GMASK];
        end
        if (wr_sc && csr_be_i[2])
        begin
            cuc_d  = csr_wdata_i[CM_CUC_LO +: 4];
            ruc_d  = csr_wdata_i[CM_RUC_LO +: 4];
            cstb_d = (cuc_d != 4'h0);
            rstb_d = (ruc_d != 4'h0);
        end

        gptr_d  = wr_gp ? merge(gptr_q, csr_wdata_i, csr_be_i)
                        : gptr_q;
        port_d  = wr_pt ? merge(port_q, csr_wdata_i, csr_be_i) : port_q;
        // the function runs only when the selector byte is written
        pstb_d  = wr_pt && csr_be_i[0];
        fl_we_d = (wr_nv && csr_be_i[0]) ? csr_wdata_i[FL_WE]
                                         : fl_we_q;
        ee_d    = (wr_nv && csr_be_i[2]) ? csr_wdata_i[EE_DI:EE_SK]
                                         : ee_q;

        mg_ie_d  = mg_ie_q;
        mg_rdy_d = mg_rdy_q;
        mg_op_d  = mg_op_q;
        mg_phy_d = mg_phy_q;
        mg_reg_d = mg_reg_q;
        mg_dat_d = mg_dat_q;
        mg_go_d  = 1'b0;
        // writes until the done pulse has passed are dropped whole, so the
        // frame in flight can never see its fields change
        if (wr_mg && !mg_busy && !mg_go_q && !mg_done && csr_be_i == 4'hF)
        begin
            mg_ie_d = csr_wdata_i[MG_IE];
            if (csr_wdata_i[MG_OP_LO +: 2] == OP_WRITE ||
                csr_wdata_i[MG_OP_LO +: 2] == OP_READ)
            begin
                mg_rdy_d = csr_wdata_i[MG_RDY];
                mg_op_d  = csr_wdata_i[MG_OP_LO +: 2];
                mg_phy_d = csr_wdata_i[MG_PHY_LO +: 5];
                mg_reg_d = csr_wdata_i[MG_REG_LO +: 5];
                mg_dat_d = csr_wdata_i[15:0];
                mg_go_d  = 1'b1;
            end
        end
        if (mg_done)
        begin
            mg_rdy_d = 1'b1;
            if (mg_op_q == OP_READ)
                mg_dat_d = mg_rdata;
        end

        pend = (ev_q[EV_CX]  && !mask_q[5]) ||
               (ev_q[EV_FR]  && !mask_q[4]) ||
               (ev_q[EV_CNA] && !mask_q[3]) ||
               (ev_q[EV_RNR] && !mask_q[2]) ||
               (ev_q[EV_MDI] && mg_ie_q && !mask_q[1]) ||
               (ev_q[EV_FCP] && !mask_q[0]) ||
               ev_q[EV_SWI];
        inta_n_d = !(pend && !gmask_q);

        rdata_d = rdata_q;
        if (csr_rd_i)
        begin
            case (csr_addr_i)
                OFS_STAT_CMD: rdata_d = {mask_q, 1'b0, gmask_q, 8'h00,
                                         status_w};
                OFS_GEN_PTR:  rdata_d = gptr_q;
                OFS_PORT:     rdata_d = port_q;
                OFS_NVM:      rdata_d = {12'h000, eep_sync_q[1], ee_q,
                                         15'h0000, fl_we_q};
                OFS_MGMT:     rdata_d = {2'b00, mg_ie_q, mg_rdy_q, mg_op_q,
                                         mg_phy_q, mg_reg_q, mg_dat_q};
                default:      rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (sys_rst_i)
        begin
            ev_q       <= EV_RESET;
            mask_q     <= CM_MASK_RST;
            gmask_q    <= 1'b0;
            cuc_q      <= 4'h0;
            ruc_q      <= 4'h0;
            cstb_q     <= 1'b0;
            rstb_q     <= 1'b0;
            gptr_q     <= 32'h0000_0000;
            port_q     <= 32'h0000_0000;
            pstb_q     <= 1'b0;
            fl_we_q    <= 1'b0;
            ee_q       <= 3'h0;
            mg_ie_q    <= 1'b0;
            mg_rdy_q   <= 1'b0;
            mg_op_q    <= 2'h0;
            mg_phy_q   <= 5'h00;
            mg_reg_q   <= 5'h00;
            mg_dat_q   <= 16'h0000;
            mg_go_q    <= 1'b0;
            cu_prev_q  <= CU_IDLE;
            ru_prev_q  <= 4'h0;
            rdata_q    <= 32'h0000_0000;
            inta_n_q   <= 1'b1;
            eep_sync_q <= 2'h0;
        end
        else
        begin
            ev_q       <= ev_d;
            mask_q     <= mask_d;
            gmask_q    <= gmask_d;
            cuc_q      <= cuc_d;
            ruc_q      <= ruc_d;
            cstb_q     <= cstb_d;
            rstb_q     <= rstb_d;
            gptr_q     <= gptr_d;
            port_q     <= port_d;
            pstb_q     <= pstb_d;
            fl_we_q    <= fl_we_d;
            ee_q       <= ee_d;
            mg_ie_q    <= mg_ie_d;
            mg_rdy_q   <= mg_rdy_d;
            mg_op_q    <= mg_op_d;
            mg_phy_q   <= mg_phy_d;
            mg_reg_q   <= mg_reg_d;
            mg_dat_q   <= mg_dat_d;
            mg_go_q    <= mg_go_d;
            cu_prev_q  <= cu_state_i;
            ru_prev_q  <= ru_state_i;
            rdata_q    <= rdata_d;
            inta_n_q   <= inta_n_d;
            eep_sync_q <= {eep_sync_q[0], eep_do_i};
        end
    end

    hsc_mdio_shifter u_mdio
    (
        .ref_clk_i  (ref_clk_i),
        .sys_rst_i  (sys_rst_i),
        .start_i    (mg_go_q),
        .op_i       (mg_op_q),
        .phy_addr_i (mg_phy_q),
        .reg_addr_i (mg_reg_q),
        .wdata_i    (mg_dat_q),
        .busy_o     (mg_busy),
        .done_o     (mg_done),
        .rdata_o    (mg_rdata),
        .mdc_o      (mdc_o),
        .mdio_i     (mdio_i),
        .mdio_o     (mdio_o),
        .mdio_oe_o  (mdio_oe_o)
    );

    assign csr_rdata_o   = rdata_q;
    assign cu_cmd_o      = cuc_q;
    assign cu_cmd_stb_o  = cstb_q;
    assign ru_cmd_o      = ruc_q;
    assign ru_cmd_stb_o  = rstb_q;
    assign gen_ptr_o     = gptr_q;
    assign port_func_o   = port_q[3:0];
    assign port_arg_o    = port_q[31:4];
    assign port_stb_o    = pstb_q;
    assign flash_wr_en_o = fl_we_q;
    assign eep_sk_o      = ee_q[0];
    assign eep_cs_o      = ee_q[1];
    assign eep_di_o      = ee_q[2];
    assign inta_n_o      = inta_n_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_cx_sets: assert property (cu_cmd_done_i |=> ev_q[EV_CX])
        else $error("command done did not set its status bit");
    a_fr_sets: assert property (rx_frame_done_i |=> ev_q[EV_FR])
        else $error("frame received did not set its status bit");
    a_cna_sets: assert property (
        (cu_prev_q == CU_ACTIVE && (cu_state_i == CU_IDLE ||
         cu_state_i == CU_SUSP)) |=> ev_q[EV_CNA])
        else $error("command unit stop not flagged");
    a_rnr_sets: assert property (
        (ru_prev_q == RU_READY && ru_state_i != RU_READY) |=> ev_q[EV_RNR])
        else $error("receive unit leaving ready not flagged");
    a_swi_raise: assert property (
        (ev_set[EV_SWI] && !gmask_d) |=> ##1 !inta_n_o)
        else $error("software interrupt request did not raise the line");
    a_gmask_quiet: assert property (gmask_q |=> inta_n_o)
        else $error("interrupt line asserted under global mask");
    a_mask_event: assert property (
        (mask_q[5] && ev_q == 8'h80 && !gmask_q) |=> inta_n_o)
        else $error("masked event drove the interrupt line");
    a_mgmt_ready: assert property (
        mg_done |=> (mg_rdy_q && ev_q[EV_MDI]))
        else $error("ready or event bit missing after transaction");
    a_mgmt_go: assert property (
        (wr_mg && !mg_busy && !mg_go_q && !mg_done && csr_be_i == 4'hF &&
         csr_wdata_i[27:26] == OP_READ) |=> ##1 mg_busy)
        else $error("read command did not start a frame");
    a_set_wins: assert property (
        (ev_set[EV_SWI] && ev_clr[EV_SWI]) |=> ev_q[EV_SWI])
        else $error("event lost to a same-cycle acknowledge");
    a_ack_clears: assert property (
        (ev_clr[EV_FR] && !rx_frame_done_i) |=> !ev_q[EV_FR])
        else $error("acknowledge did not clear the event");

    cover property (mg_done && mg_op_q == OP_WRITE);
    cover property ($fell(inta_n_o));
    cover property (ev_set[EV_SWI] && gmask_q);
endmodule

// [hsc_phy_model.sv]
// Purpose: PHY end of the management link
// Assumes: 64-bit frames, mdc low between frames
// Notes:   drives turnaround low and read data only
module hsc_phy_model
(
    input  wire logic        rst_i,
    input  wire logic        mdc_i,
    input  wire logic        mdio_i,
    input  wire logic [15:0] rd_val_i,
    output logic             drv_o,
    output logic             val_o,
    output logic [63:0]      frame_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // start counted so a reset edge missed at time zero does no harm
    logic [5:0] cnt_q = 6'h00;
    logic       rd_q  = 1'b0;
    always @(posedge mdc_i or posedge rst_i)
    begin
        cnt_q <= rst_i ? 6'h00 : cnt_q + 6'h01;
        frame_o <= {frame_o[62:0], mdio_i};
        if (rst_i || cnt_q == 6'h23)
            rd_q <= !rst_i && {frame_o[0], mdio_i} == 2'h2;
    end
    // new bit only after mdc falls, so the sampling edge sees it settled
    always @(negedge mdc_i)
    begin
        drv_o <= rd_q && cnt_q > 6'h2E;
        val_o <= cnt_q > 6'h2F && rd_val_i[6'h3F - cnt_q];
    end
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the host register front end
// Assumes: 20 MHz clock, one-cycle read and write strobes
// Notes:   the PHY model answers every read with 16'hC3A5
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import hsc_pkg::*;
    logic        clk, rst, wr, rd, cxd, frd, fpd, eepd, pdrv, pval, mdio;
    logic        inta_n, mdc, m_o, m_oe, fl, sk, cs, di;
    logic        cstb, rstb, pstb;
    logic [1:0]  cu_st;
    logic [3:0]  be, ru_st, cmd_unit_command, rx_unit_command, pfunc;
    logic [4:0]  addr;
    logic [27:0] parg;
    logic [31:0] wd, rdat, gptr, d;
    logic [63:0] frame;
    int          error_cnt, compares;
    // a released line floats high through the pull-up
    assign mdio = m_oe ? m_o : (pdrv === 1'b1 ? pval : 1'b1);
    hsc_csr i_dut (.ref_clk_i(clk), .sys_rst_i(rst), .csr_addr_i(addr),
        .csr_wr_i(wr), .csr_rd_i(rd), .csr_be_i(be), .csr_wdata_i(wd),
        .csr_rdata_o(rdat), .cu_cmd_done_i(cxd), .rx_frame_done_i(frd),
        .flow_pause_i(fpd), .cu_state_i(cu_st), .ru_state_i(ru_st),
        .cu_cmd_o(cmd_unit_command), .cu_cmd_stb_o(cstb),
        .ru_cmd_o(rx_unit_command), .ru_cmd_stb_o(rstb),
        .gen_ptr_o(gptr), .port_func_o(pfunc), .port_arg_o(parg),
        .port_stb_o(pstb), .flash_wr_en_o(fl), .eep_sk_o(sk), .eep_cs_o(cs),
        .eep_di_o(di), .eep_do_i(eepd), .mdc_o(mdc), .mdio_i(mdio),
        .mdio_o(m_o), .mdio_oe_o(m_oe), .inta_n_o(inta_n));
    hsc_phy_model i_phy (.rst_i(rst), .mdc_i(mdc), .mdio_i(mdio),
        .rd_val_i(16'hC3A5), .drv_o(pdrv), .val_o(pval), .frame_o(frame));
    task automatic chk(string n, logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr32(logic [4:0] a, logic [3:0] b, logic [31:0] v);
        @(posedge clk);
        addr <= a;
        be <= b;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd32(logic [4:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic fire(int i, int m);
        @(posedge clk);
        case (i)
            0: cxd <= 1'b1;
            1: frd <= 1'b1;
            2: cu_st <= (m != 0) ? CU_SUSP : CU_IDLE;
            3: ru_st <= 4'h0;
            default: fpd <= 1'b1;
        endcase
        @(posedge clk);
        {cxd, frd, fpd} <= 3'h0;
        cu_st <= CU_ACTIVE;
        ru_st <= RU_READY;
    endtask
    task automatic t_events();
        int bn[5] = '{15, 14, 13, 12, 8};
        int mb[5] = '{31, 30, 29, 28, 26};
        for (int i = 0; i < 5; i++)
            for (int m = 0; m < 2; m++)
            begin
                wr32(OFS_STAT_CMD, 4'h8, 32'(m) << mb[i]);
                fire(i, m);
                cyc(3);
                rd32(OFS_STAT_CMD);
                chk("event", 32'({d[bn[i]], inta_n}), 32'(2 + m));
                wr32(OFS_STAT_CMD, 4'h2, 32'h1 << bn[i]);
                cyc(2);
                rd32(OFS_STAT_CMD);
                chk("ack", 32'({d[bn[i]], inta_n}), 32'h1);
            end
        $display("events done");
    endtask
    task automatic t_swi();
        wr32(OFS_STAT_CMD, 4'h8, 32'h0200_0000);
        cyc(3);
        rd32(OFS_STAT_CMD);
        chk("swi", 32'({d[25], d[10], inta_n}), 32'h2);
        // set beats the acknowledge in the same write
        wr32(OFS_STAT_CMD, 4'hA, 32'h0300_0400);
        cyc(3);
        rd32(OFS_STAT_CMD);
        chk("gmask", 32'({d[10], inta_n}), 32'h3);
        wr32(OFS_STAT_CMD, 4'hA, 32'h0000_0400);
        cyc(3);
        chk("swi ack", 32'(inta_n), 32'h1);
        $display("swi done");
    endtask
    task automatic t_regs();
        wr32(OFS_STAT_CMD, 4'h4, 32'h0053_0000);
        #1 chk("unit stb", 32'({cstb, rstb}), 32'h3);
        wr32(OFS_PORT, 4'hF, 32'h1234_5672);
        #1 chk("port stb", 32'(pstb), 32'h1);
        wr32(OFS_NVM, 4'hF, 32'h0007_0001);
        wr32(OFS_GEN_PTR, 4'hF, 32'hA5C3_1E0F);
        rd32(OFS_GEN_PTR);
        chk("ptr", d, 32'hA5C3_1E0F);
        chk("ptr out", gptr, 32'hA5C3_1E0F);
        chk("unit cmd", 32'({cmd_unit_command, rx_unit_command}), 32'h53);
        chk("port", {parg, pfunc}, 32'h1234_5672);
        rd32(OFS_NVM);
        chk("nvm", 32'({fl, sk, cs, di, d[19]}), 32'h1F);
        rd32(5'h14);
        chk("unmapped", d, 32'h0);
        $display("regs done");
    endtask
    task automatic t_mgmt(logic [1:0] op, logic ie);
        logic [15:0] v;
        v = (op == OP_READ) ? 16'h3C5A : 16'hBEEF;
        wr32(OFS_MGMT, 4'hF, {2'h0, ie, 1'b0, op, 5'h0B, 5'h11, v});
        d = 32'h0;
        for (int n = 0; n < 400 && !d[28]; n++)
            rd32(OFS_MGMT);
        chk("ready", 32'(d[28]), 32'h1);
        if (op == OP_READ)
            v = 16'hC3A5;
        chk("rdata", 32'(d[15:0]), 32'(v));
        chk("frame hi", frame[63:32], PREAMBLE);
        chk("frame lo", frame[31:0], {FR_START, op, 10'h171, 2'h2, v});
        cyc(2);
        rd32(OFS_STAT_CMD);
        chk("mgmt ev", 32'({d[11], inta_n}), 32'({1'b1, !ie}));
        wr32(OFS_STAT_CMD, 4'h2, 32'h0800);
        cyc(3);
        chk("mgmt ack", 32'(inta_n), 32'h1);
        $display("mgmt done");
    endtask
    task automatic results();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        {rst, wr, rd, cxd, frd, fpd, eepd} = 7'h41;
        {addr, be, wd} = '0;
        cu_st = CU_ACTIVE;
        ru_st = RU_READY;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd32(OFS_STAT_CMD);
        chk("reset", {d[31:1], inta_n}, 32'h91);
        t_events();
        t_swi();
        t_regs();
        t_mgmt(OP_WRITE, 1'b1);
        t_mgmt(OP_READ, 1'b0);
        results();
    end
    initial
    begin
        #1_000_000;
        error_cnt++;
        results();
    end
endmodule
